//--- design/sarcr_fifo.v
// Result FIFO with valid and ready on both sides.
`default_nettype none

module sarcr_fifo #(
   parameter W = 12,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Discards all stored words
   input wire flush_i,
   // Write side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   // Read side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);

   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ff;
   reg [AW:0] rd_ff;
   wire push;
   wire pop;

   // Pointers carry one extra bit so full and empty stay distinct.
   assign in_ready_o = (wr_ff[AW-1:0] != rd_ff[AW-1:0]) || (wr_ff[AW] == rd_ff[AW]);
   assign out_valid_o = (wr_ff != rd_ff);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ff[AW-1:0]];

   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ff[AW-1:0]] <= in_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (!nrst_i || flush_i) begin
         wr_ff <= {(AW+1){1'b0}};
         rd_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ff <= wr_ff + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ff <= rd_ff + {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule

`default_nettype wire

//--- design/sarcr_sync.v
// Two flip-flop synchroniser for inputs that arrive from outside the clock domain.
`default_nettype none

module sarcr_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Asynchronous input and its synchronised copy
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule

`default_nettype wire

//--- design/sarcr_top.v
// Conversion control, successive approximation and serial readout of the converter.
//
// Behaviour
// - Start rising: wake, data low, track.
// - Start falling: sample, hold, begin conversion.
// - Within 3.7 us: done, shutdown, MSB out.
// - Start low: stay in automatic shutdown.
// - Single-ended: same pattern picks second channel.
// - Incomplete readout at rising: second mode next.
// - Unipolar binary, bipolar two's complement.
// - Ten result bits MSB first, two sub-bits.
// - Data changes on falling serial clock.
// - After last sub-bit, output goes high-impedance.
// - Conversion paced by internal 4 MHz oscillator.
// - Serial clock from zero up to 8 MHz.
`include "sarcr_map.vh"
`default_nettype none

module sarcr_top #(
   parameter DIFFERENTIAL = 1
) (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Host pins
   input wire conversion_start_pin_i,
   input wire sclk_i,
   output wire dout_o,
   output wire dout_oe_o,
   // Analog front end
   input wire comparator_i,
   output wire [`SARCR_WORD_BITS-1:0] dac_code_o,
   output wire track_o,
   output wire hold_o,
   output wire shutdown_o,
   output wire second_channel_o,
   output wire bipolar_o
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [3:0] ST_SHUT = 4'h1;
   localparam [3:0] ST_TRACK = 4'h2;
   localparam [3:0] ST_CONV = 4'h4;
   localparam [3:0] ST_PUSH = 4'h8;
   // The oscillator period is rounded up to whole clocks, so trials run slow, never fast.
   localparam [5:0] OSC_LAST = `SARCR_OSC_LAST;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire [1:0] pins_sync;
   wire start_s;
   wire sclk_s;
   reg start_prev_ff;
   reg sclk_prev_ff;
   wire start_rise;
   wire start_fall;
   wire sclk_fall;
   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [5:0] tick_cnt_ff;
   wire osc_tick;
   reg [`SARCR_WORD_BITS-1:0] sar_ff;
   reg [`SARCR_WORD_BITS-1:0] nxt_sar;
   reg [`SARCR_WORD_BITS-1:0] mask_ff;
   reg [`SARCR_WORD_BITS-1:0] nxt_mask;
   reg second_ff;
   reg nxt_second;
   reg done_ff;
   reg drive_ff;
   reg active_ff;
   reg [`SARCR_WORD_BITS-1:0] shift_ff;
   reg [3:0] bit_cnt_ff;
   wire [`SARCR_WORD_BITS-1:0] result;
   wire push_valid;
   wire push_ready;
   wire pop_valid;
   wire pop_ready;
   wire [`SARCR_WORD_BITS-1:0] pop_data;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   sarcr_sync #(
      .W(2)
   ) u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i({conversion_start_pin_i, sclk_i}),
      .sync_o(pins_sync)
   );

   assign start_s = pins_sync[1];
   assign sclk_s = pins_sync[0];
   // Both pins pass two flops; a serial clock level must last one full clock to count.
   // Edge registers reset to the idle pin levels, so no false edge follows reset.

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         start_prev_ff <= 1'b0;
         sclk_prev_ff <= 1'b0;
      end else begin
         start_prev_ff <= start_s;
         sclk_prev_ff <= sclk_s;
      end
   end

   assign start_rise = start_s && !start_prev_ff;
   assign start_fall = !start_s && start_prev_ff;
   // Edges are found by sampling, so any serial clock up to the sampling limit works.
   // full clock range
   assign sclk_fall = !sclk_s && sclk_prev_ff;

   // ----------------------------------------------------------------
   // Internal oscillator
   // ----------------------------------------------------------------
   // internal conversion clock
   // The counter only runs while converting, so shutdown keeps it still.
   always @(posedge clk_i) begin
      if (!nrst_i || state_ff != ST_CONV) begin
         tick_cnt_ff <= `SARCR_RST_TICK;
      end else if (tick_cnt_ff == OSC_LAST) begin
         tick_cnt_ff <= `SARCR_RST_TICK;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 6'h01;
      end
   end

   assign osc_tick = (state_ff == ST_CONV) && (tick_cnt_ff == OSC_LAST);

   // ----------------------------------------------------------------
   // Conversion control
   // ----------------------------------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_sar = sar_ff;
      nxt_mask = mask_ff;
      nxt_second = second_ff;
      case (state_ff)
         ST_SHUT: begin
            if (start_rise) begin
               nxt_state = ST_TRACK;
            end
         end
         ST_TRACK: begin
            if (start_fall) begin
               nxt_state = ST_CONV;
               nxt_sar = `SARCR_FIRST_TRIAL;
               nxt_mask = `SARCR_FIRST_TRIAL;
            end
         end
         ST_CONV: begin
            // One trial per oscillator period; twelve trials end well inside 3.7 us.
            if (osc_tick) begin
               if (!comparator_i) begin
                  nxt_sar = sar_ff & ~mask_ff;
               end
               nxt_mask = mask_ff >> 1;
               nxt_sar = nxt_sar | (mask_ff >> 1);
               if (mask_ff[0]) begin
                  nxt_state = ST_PUSH;
               end
            end
         end
         ST_PUSH: begin
            // The buffer was flushed at the rising edge, so it has room here.
            // finish and shut down
            if (push_ready) begin
               nxt_state = ST_SHUT;
            end
         end
         default: begin
            nxt_state = ST_SHUT;
         end
      endcase
      // A rising start edge always restarts acquisition, whatever was in progress.
      if (start_rise) begin
         nxt_state = ST_TRACK;
         nxt_second = !done_ff;
      end
   end

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         state_ff <= ST_SHUT;
         sar_ff <= `SARCR_RST_WORD;
         mask_ff <= `SARCR_RST_WORD;
         second_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sar_ff <= nxt_sar;
         mask_ff <= nxt_mask;
         second_ff <= nxt_second;
      end
   end

   // Single-ended parts never flip, so they always send straight binary.
   // two's complement flips MSB
   assign result = (DIFFERENTIAL != 0 && second_ff) ?
      {~sar_ff[`SARCR_MSB_POS], sar_ff[`SARCR_MSB_POS-1:0]} : sar_ff;
   assign push_valid = (state_ff == ST_PUSH);

   // ----------------------------------------------------------------
   // Front-end outputs
   // ----------------------------------------------------------------
   assign dac_code_o = sar_ff;
   assign track_o = (state_ff == ST_TRACK);
   assign hold_o = (state_ff == ST_CONV);
   assign shutdown_o = (state_ff == ST_SHUT);
   assign second_channel_o = (DIFFERENTIAL == 0) && second_ff;
   assign bipolar_o = (DIFFERENTIAL != 0) && second_ff;

   // ----------------------------------------------------------------
   // Result buffer
   // ----------------------------------------------------------------
   // Stale words are dropped when a new acquisition starts.
   sarcr_fifo #(
      .W(`SARCR_WORD_BITS),
      .DEPTH(`SARCR_FIFO_DEPTH),
      .AW(`SARCR_FIFO_AW)
   ) u_fifo (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .flush_i(start_rise),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_data_i(result),
      .out_valid_o(pop_valid),
      .out_ready_i(pop_ready),
      .out_data_o(pop_data)
   );

   // A word is loaded only between readouts, so a shift never mixes two results.
   assign pop_ready = drive_ff && !active_ff && !start_rise;

   // ----------------------------------------------------------------
   // Serial readout
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         drive_ff <= 1'b0;
         active_ff <= 1'b0;
         done_ff <= 1'b1;
         shift_ff <= `SARCR_RST_WORD;
         bit_cnt_ff <= `SARCR_RST_CNT;
      end else if (start_rise) begin
         drive_ff <= 1'b1;
         active_ff <= 1'b0;
         shift_ff <= `SARCR_RST_WORD;
         bit_cnt_ff <= `SARCR_RST_CNT;
      end else if (pop_valid && pop_ready) begin
         active_ff <= 1'b1;
         shift_ff <= pop_data;
         bit_cnt_ff <= `SARCR_RST_CNT;
      end else if (sclk_fall && active_ff && state_ff != ST_CONV) begin
         if (bit_cnt_ff == `SARCR_LAST_BIT) begin
            drive_ff <= 1'b0;
            active_ff <= 1'b0;
            done_ff <= 1'b1;
            shift_ff <= `SARCR_RST_WORD;
         end else begin
            shift_ff <= {shift_ff[`SARCR_MSB_POS-1:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end else if (start_fall) begin
         // A started conversion counts as unread until all bits leave.
         done_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Serial output pin
   // ----------------------------------------------------------------
   assign dout_o = shift_ff[`SARCR_MSB_POS];
   assign dout_oe_o = drive_ff;

endmodule

`default_nettype wire

//--- dv/sarcr_host_model.sv
// Host model: start pin driver and serial master facing the converter.
`default_nettype none
module sarcr_host_model (
   // Clock
   input wire logic clk_i,
   // Converter pins
   input wire logic dout_i,
   input wire logic dout_oe_i,
   output logic pin_o,
   output logic sclk_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic line_ff;
   logic line;
   initial begin
      pin_o = 1'b0;
      sclk_o = 1'b0;
      line_ff = 1'b0;
   end
   // A released line has no pull, so it shows the inverse of the last driven bit.
   always @(posedge clk_i) line_ff <= dout_oe_i ? ~dout_i : line_ff;
   assign line = dout_oe_i ? dout_i : line_ff;
   task automatic wake(input logic two);
      @(negedge clk_i);
      pin_o = 1'b1;
      if (two) begin
         repeat (8) @(negedge clk_i);
         pin_o = 1'b0;
         repeat (8) @(negedge clk_i);
         pin_o = 1'b1;
      end
   endtask
   task automatic sample(input logic noisy);
      repeat (350) @(negedge clk_i);
      pin_o = 1'b0;
      // A noisy host clocks during the conversion, which the converter must ignore.
      repeat (noisy ? 4 : 0) begin
         repeat (8) @(negedge clk_i);
         sclk_o = 1'b1;
         repeat (8) @(negedge clk_i);
         sclk_o = 1'b0;
      end
      repeat (noisy ? 861 : 925) @(negedge clk_i);
   endtask
   task automatic read(input int n, output logic [11:0] w);
      w = 12'h000;
      repeat (n) begin
         sclk_o = 1'b1;
         w = {w[10:0], line};
         repeat (8) @(negedge clk_i);
         sclk_o = 1'b0;
         repeat (8) @(negedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

//--- dv/sarcr_top_sva.sv
// Checker of the converter control and serial readout ports.
`default_nettype none
module sarcr_top_chk #(
   parameter DIFFERENTIAL = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Pins and state
   input wire logic conversion_start_pin_i,
   input wire logic sclk_i,
   input wire logic dout_o,
   input wire logic dout_oe_o,
   input wire logic track_o,
   input wire logic hold_o,
   input wire logic shutdown_o,
   input wire logic second_channel_o,
   input wire logic bipolar_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] fall_cnt_ff;
   logic [9:0] hold_cnt_ff;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   // Serial falls since the last wake, and hold length in clocks.
   always @(posedge clk_i) begin
      if (!nrst_i || $rose(track_o)) begin
         fall_cnt_ff <= 4'h0;
      end else if (dout_oe_o && !hold_o && $fell(sclk_i)) begin
         fall_cnt_ff <= fall_cnt_ff + 4'h1;
      end
      hold_cnt_ff <= hold_o ? hold_cnt_ff + 10'h001 : 10'h000;
   end
   property p_wake;
      $rose(conversion_start_pin_i) |-> ##[2:6] (track_o && dout_oe_o && !dout_o);
   endproperty
   a_wake: assert property (p_wake) else $error("no wake after start rise");
   property p_hold;
      $fell(conversion_start_pin_i) && track_o |-> ##[2:6] hold_o;
   endproperty
   a_hold: assert property (p_hold) else $error("no hold after start fall");
   property p_done;
      $rose(hold_o) |-> ##[1:925] (shutdown_o || track_o);
   endproperty
   a_done: assert property (p_done) else $error("conversion too long");
   property p_osc;
      $fell(hold_o) && !conversion_start_pin_i |-> hold_cnt_ff inside {[10'h2EE:10'h2F8]};
   endproperty
   a_osc: assert property (p_osc) else $error("conversion length off");
   property p_shut;
      shutdown_o |-> !track_o && !hold_o;
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown while active");
   property p_quiet;
      hold_o && $past(hold_o) |-> $stable(dout_o) && $stable(dout_oe_o);
   endproperty
   a_quiet: assert property (p_quiet) else $error("output moved converting");
   property p_shift;
      $changed(dout_o) && shutdown_o && $past(shutdown_o, 3) |-> !$past(sclk_i, 3);
   endproperty
   a_shift: assert property (p_shift) else $error("data moved off falling edge");
   property p_release;
      $fell(dout_oe_o) |-> fall_cnt_ff == 4'hC && !dout_o;
   endproperty
   a_release: assert property (p_release) else $error("release not at twelfth bit");
   property p_variant;
      DIFFERENTIAL != 0 ? !second_channel_o : !bipolar_o;
   endproperty
   a_variant: assert property (p_variant) else $error("mode of other variant");
   property p_mode;
      hold_o && $past(hold_o) |-> $stable(bipolar_o) && $stable(second_channel_o);
   endproperty
   a_mode: assert property (p_mode) else $error("mode moved converting");
   c_bip: cover property ($rose(bipolar_o));
   c_done: cover property ($rose(shutdown_o));
   c_read: cover property ($fell(dout_oe_o));
endmodule
bind sarcr_top sarcr_top_chk #(.DIFFERENTIAL(DIFFERENTIAL)) sarcr_top_chk_i (
   .clk_i(clk_i), .nrst_i(nrst_i), .conversion_start_pin_i(conversion_start_pin_i),
   .sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .track_o(track_o),
   .hold_o(hold_o), .shutdown_o(shutdown_o), .second_channel_o(second_channel_o),
   .bipolar_o(bipolar_o)
);
`default_nettype wire

//--- dv/tb_sarcr_top.sv
// Self-checking bench of the converter control and serial readout block.
`default_nettype none
module tb_sarcr_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cmp = 1'b0;
   logic [11:0] ain = 12'h000;
   logic [11:0] dac;
   logic pin, sclk, dout, oe, track, hold, shdn, sec, bip;
   logic cmp2 = 1'b0;
   logic [11:0] dac2;
   logic sec2, bip2;
   int failures = 0;
   int checks = 0;
   always #2 clk_i = ~clk_i;
   // The analog input is a fixed code, so the comparator is a compare.
   always @(negedge clk_i) cmp <= (ain >= dac);
   always @(negedge clk_i) cmp2 <= (ain >= dac2);
   sarcr_top sarcr_top_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .conversion_start_pin_i(pin), .sclk_i(sclk),
      .dout_o(dout), .dout_oe_o(oe), .comparator_i(cmp), .dac_code_o(dac),
      .track_o(track), .hold_o(hold), .shutdown_o(shdn),
      .second_channel_o(sec), .bipolar_o(bip)
   );
   sarcr_host_model sarcr_host_model_i (
      .clk_i(clk_i), .dout_i(dout), .dout_oe_i(oe), .pin_o(pin), .sclk_o(sclk)
   );
   // The single-ended variant shares the pins and is only watched for its mode.
   sarcr_top #(
      .DIFFERENTIAL(0)
   ) sarcr_top_se_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .conversion_start_pin_i(pin), .sclk_i(sclk),
      .dout_o(), .dout_oe_o(), .comparator_i(cmp2), .dac_code_o(dac2),
      .track_o(), .hold_o(), .shutdown_o(),
      .second_channel_o(sec2), .bipolar_o(bip2)
   );
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Wake, check tracking, acquire and wait out the conversion.
   task automatic conv(input logic two, input logic noisy, input logic [11:0] code);
      ain = code;
      sarcr_host_model_i.wake(two);
      repeat (6) @(negedge clk_i);
      chk(12'({track, shdn, oe, dout}), 12'h00A);
      sarcr_host_model_i.sample(noisy);
      chk(12'({track, hold, shdn}), 12'h001);
   endtask
   task automatic sc_reset();
      chk(12'({oe, shdn, track, hold, bip, sec}), 12'h010);
   endtask
   task automatic sc_unipolar();
      logic [11:0] w;
      conv(1'b0, 1'b0, 12'hA5C);
      chk(12'(dout), 12'h001);
      chk(12'({sec2, bip2, bip}), 12'h000);
      sarcr_host_model_i.read(12, w);
      chk(w, 12'hA5C);
      chk(12'(oe), 12'h000);
   endtask
   task automatic sc_bipolar();
      logic [11:0] w;
      logic [11:0] b;
      conv(1'b1, 1'b0, 12'h35A);
      chk(12'(bip), 12'h001);
      chk(12'({sec2, bip2, sec}), 12'h004);
      sarcr_host_model_i.read(8, w);
      sarcr_host_model_i.read(8, b);
      chk(w, 12'h0B5);
      chk(12'(b[7:4]), 12'h00A);
      chk(12'(oe), 12'h000);
   endtask
   task automatic sc_partial();
      logic [11:0] w;
      conv(1'b0, 1'b0, 12'hFFF);
      chk(12'(bip), 12'h000);
      sarcr_host_model_i.read(5, w);
      chk(w, 12'h01F);
      conv(1'b0, 1'b1, 12'h000);
      chk(12'({sec2, bip}), 12'h003);
      sarcr_host_model_i.read(12, w);
      chk(w, 12'h800);
   endtask
   initial begin
      repeat (16) @(negedge clk_i);
      nrst_i = 1'b1;
      @(negedge clk_i);
      sc_reset();
      sc_unipolar();
      sc_bipolar();
      sc_partial();
      end_of_test();
   end
   // The run needs about 6000 clocks, so this limit means a hang.
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      end_of_test();
   end
endmodule
`default_nettype wire

//--- shared/sarcr_map.vh
// Constants of the converter control and serial readout block.
`ifndef SARCR_MAP_VH
`define SARCR_MAP_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SARCR_CLK_PERIOD_NS 4
`define SARCR_OSC_PERIOD_NS 250
`define SARCR_CONV_MAX_NS 3700
`define SARCR_OSC_CYCLES ((`SARCR_OSC_PERIOD_NS + `SARCR_CLK_PERIOD_NS - 1) / `SARCR_CLK_PERIOD_NS)
`define SARCR_OSC_LAST 6'h3E
`define SARCR_CONV_MAX_CYCLES (`SARCR_CONV_MAX_NS / `SARCR_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Result format
// ----------------------------------------------------------------
`define SARCR_RES_BITS 10
`define SARCR_SUB_BITS 2
`define SARCR_WORD_BITS 12
`define SARCR_LAST_BIT 4'hB
`define SARCR_MSB_POS 11
`define SARCR_FIRST_TRIAL 12'h800
`define SARCR_FIFO_DEPTH 8
`define SARCR_FIFO_AW 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SARCR_RST_WORD 12'h000
`define SARCR_RST_CNT 4'h0
`define SARCR_RST_TICK 6'h00

`endif
